// ==== irq_arbiter_dev.sv ====
// Functional notes
// - mask blocks levels at or below it, not seven
// - seven request lines, one lowest, seven highest
// - requester holds line low until its acknowledge
// - level seven edge detected, mask drop retriggers
// - request valid after two consecutive low samples
// - service starts at boundary or exception end
// - level not latched; highest unmasked wins
// - acknowledge carries level; mask takes level
// - function code all ones, fixed acknowledge address
// - requester decodes level, contends when matching
// - serial four-bit contention; unique nonzero values
// - zero value, no contention: bus error, spurious
// - always arbitrate; external only if unit wins
// - unit value resets fifteen, others zero
// - winner terminates; internal gives vector, termination
// - external device returns vector or autovector
// - autovector request yields level-derived vector
// - bus monitor timeout: bus error, spurious
// - chip-select autovector only on external cycle
// - timer level field; zero disables timer
// - timer beats pins at same level
// - stack, supervisor on, trace off, fetch vector
`default_nettype none
module irq_arbiter_dev #(
   parameter logic [7:0] SPURIOUS_VECTOR = 8'h18,
   parameter logic [7:0] AUTOVECTOR_BASE = 8'h18,
   parameter int BUS_MON_CYCLES = 64
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // link to requesters
   irq_link_if.device link,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // processor side
   input wire logic instr_boundary,
   input wire logic exc_done,
   input wire logic periodic_tick,
   input wire logic autovector_request_tied,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_data,
   output logic stack_req,
   output logic [15:0] stacked_sr,
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   output logic [31:0] pc
);

   localparam logic [15:0] MON_LAST = 16'(BUS_MON_CYCLES - 1);

   irq_pkg::dev_state_t state_q;
   logic [7:1] imb_seen_q, ext_seen_q, imb_valid_q, ext_valid_q, valid, req;
   logic v7_prev_q, nmi_q, nmi_set, pit_q, start, pit_hit, siu_src, stay;
   logic [2:0] mask_prev_q, ack_lvl_q, pend_lvl, pit_lvl_q;
   logic [15:0] sr_q, mon_q;
   logic [3:0] siu_arb_q;
   logic [7:1] cs_autovector_request_q;
   logic [7:0] pit_vec_q, vec_q, autovec;
   logic [31:0] vbr_q;
   logic [1:0] idx_q;
   logic in_q, any_q, spur_q, bit_q, iack_q, ext_q, bus_error_signal_q;
   logic [2:0] fc_q;
   logic [23:0] addr_q;

   function automatic logic [2:0] highest(input logic [7:1] r);
      highest = irq_pkg::LVL_NONE;
      for (int i = 1; i <= 7; i++) begin
         if (r[i]) begin
            highest = 3'(i);
         end
      end
   endfunction

   assign link.iack = iack_q;
   assign link.ext_cycle = ext_q;
   assign link.bus_error_signal = bus_error_signal_q;
   assign link.function_code_lines = fc_q;
   assign link.addr = addr_q;
   assign link.dev_arb_bit = bit_q;

   // --------------------------------------------------------------------
   // request sampling
   // --------------------------------------------------------------------
   // inputs are synchronous, so the first stage may feed the qualifier
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         imb_seen_q <= 7'h00;
         ext_seen_q <= 7'h00;
         imb_valid_q <= 7'h00;
         ext_valid_q <= 7'h00;
      end else begin
         imb_seen_q <= ~link.imb_irq_n;
         ext_seen_q <= ~link.ext_irq_n;
         imb_valid_q <= imb_seen_q & ~link.imb_irq_n;
         ext_valid_q <= ext_seen_q & ~link.ext_irq_n;
      end
   end

   assign valid = imb_valid_q | ext_valid_q;
   assign nmi_set = valid[7] & (~v7_prev_q |
      (mask_prev_q == irq_pkg::MASK_ALL && sr_q[2:0] != irq_pkg::MASK_ALL));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         v7_prev_q <= 1'h0;
         mask_prev_q <= irq_pkg::MASK_ALL;
         nmi_q <= 1'h0;
      end else begin
         v7_prev_q <= valid[7];
         mask_prev_q <= sr_q[2:0];
         if (nmi_set) begin
            nmi_q <= 1'h1;
         end else if (start && pend_lvl == irq_pkg::LVL_NMI) begin
            nmi_q <= 1'h0;
         end
      end
   end

   // --------------------------------------------------------------------
   // priority resolution
   // --------------------------------------------------------------------
   // levels are re-resolved every cycle so a later higher request wins
   always_comb begin
      req = 7'h00;
      for (int i = 1; i <= 6; i++) begin
         req[i] = (valid[i] | (pit_q && pit_lvl_q == 3'(i))) && 3'(i) > sr_q[2:0];
      end
      req[7] = nmi_q | (pit_q && pit_lvl_q == irq_pkg::LVL_NMI);
      pend_lvl = highest(req);
   end

   assign start = state_q == irq_pkg::ST_IDLE && pend_lvl != irq_pkg::LVL_NONE &&
      (instr_boundary | exc_done);
   assign pit_hit = pit_q && pit_lvl_q == ack_lvl_q;
   assign siu_src = pit_hit | ext_valid_q[ack_lvl_q];
   assign stay = in_q & (bit_q == link.arb_wire);
   assign autovec = AUTOVECTOR_BASE + {5'h00, ack_lvl_q};

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pit_q <= 1'h0;
      end else if (periodic_tick && pit_lvl_q != irq_pkg::LVL_NONE) begin
         pit_q <= 1'h1;
      end else if (pit_lvl_q == irq_pkg::LVL_NONE) begin
         pit_q <= 1'h0;
      end else if (state_q == irq_pkg::ST_ARB && idx_q == 2'h0 && stay && pit_hit) begin
         pit_q <= 1'h0;
      end
   end

   // --------------------------------------------------------------------
   // status word and configuration
   // --------------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sr_q <= irq_pkg::SR_RESET;
         stack_req <= 1'h0;
         stacked_sr <= 16'h0000;
      end else begin
         stack_req <= start;
         if (start) begin
            stacked_sr <= sr_q;
            sr_q[irq_pkg::SR_S_BIT] <= 1'h1;
            sr_q[irq_pkg::SR_T1_BIT] <= 1'h0;
            sr_q[irq_pkg::SR_T0_BIT] <= 1'h0;
            sr_q[2:0] <= pend_lvl;
         end else if (reg_write && reg_addr == irq_pkg::ADDR_SR) begin
            sr_q <= reg_wdata[15:0];
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         siu_arb_q <= irq_pkg::SIU_ARB_RESET;
         pit_lvl_q <= irq_pkg::PIT_LVL_RESET;
         pit_vec_q <= irq_pkg::PIT_VEC_RESET;
         cs_autovector_request_q <= irq_pkg::CS_AUTOVECTOR_REQUEST_RESET;
         vbr_q <= 32'h00000000;
      end else if (reg_write) begin
         unique case (reg_addr)
            irq_pkg::ADDR_ARB: siu_arb_q <= reg_wdata[3:0];
            irq_pkg::ADDR_PIT: begin
               pit_lvl_q <= reg_wdata[2:0];
               pit_vec_q <= reg_wdata[15:8];
            end
            irq_pkg::ADDR_CS: cs_autovector_request_q <= reg_wdata[7:1];
            irq_pkg::ADDR_VBR: vbr_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         unique case (reg_addr)
            irq_pkg::ADDR_SR: reg_rdata <= {16'h0000, sr_q};
            irq_pkg::ADDR_ARB: reg_rdata <= {28'h0000000, siu_arb_q};
            irq_pkg::ADDR_PIT: reg_rdata <= {16'h0000, pit_vec_q, 5'h00, pit_lvl_q};
            irq_pkg::ADDR_CS: reg_rdata <= {24'h000000, cs_autovector_request_q, 1'h0};
            irq_pkg::ADDR_VBR: reg_rdata <= vbr_q;
            irq_pkg::ADDR_LAST: reg_rdata <= {16'h0000, state_q != irq_pkg::ST_IDLE,
               spur_q, pit_q, 2'h0, ack_lvl_q, vec_q};
            irq_pkg::ADDR_PC: reg_rdata <= pc;
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // --------------------------------------------------------------------
   // acknowledge sequencer
   // --------------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= irq_pkg::ST_IDLE;
         iack_q <= 1'h0;
         ext_q <= 1'h0;
         bus_error_signal_q <= 1'h0;
         fc_q <= 3'h0;
         addr_q <= 24'h000000;
         ack_lvl_q <= irq_pkg::LVL_NONE;
         idx_q <= 2'h0;
         in_q <= 1'h0;
         any_q <= 1'h0;
         bit_q <= 1'h0;
         spur_q <= 1'h0;
         vec_q <= 8'h00;
         mon_q <= 16'h0000;
         fetch_req <= 1'h0;
         fetch_addr <= 32'h00000000;
         pc <= 32'h00000000;
      end else begin
         unique case (state_q)
            irq_pkg::ST_IDLE: if (start) begin
               iack_q <= 1'h1;
               fc_q <= irq_pkg::FC_CPU_SPACE;
               addr_q <= {irq_pkg::IACK_ADDR_HI, pend_lvl, 1'h1};
               ack_lvl_q <= pend_lvl;
               spur_q <= 1'h0;
               state_q <= irq_pkg::ST_ACK;
            end
            irq_pkg::ST_ACK: begin
               // the unit contends on behalf of the pins and the timer
               idx_q <= irq_pkg::ARB_MSB;
               in_q <= siu_src;
               bit_q <= siu_src & siu_arb_q[irq_pkg::ARB_MSB];
               any_q <= 1'h0;
               state_q <= irq_pkg::ST_ARB;
            end
            irq_pkg::ST_ARB: begin
               any_q <= any_q | link.arb_wire;
               if (idx_q != 2'h0) begin
                  in_q <= stay;
                  bit_q <= stay & siu_arb_q[idx_q - 2'h1];
                  idx_q <= idx_q - 2'h1;
               end else begin
                  in_q <= 1'h0;
                  bit_q <= 1'h0;
                  mon_q <= 16'h0000;
                  if (!(any_q | link.arb_wire)) begin
                     bus_error_signal_q <= 1'h1;
                     spur_q <= 1'h1;
                     vec_q <= SPURIOUS_VECTOR;
                     state_q <= irq_pkg::ST_VEC;
                  end else if (stay && pit_hit) begin
                     vec_q <= pit_vec_q;
                     state_q <= irq_pkg::ST_VEC;
                  end else if (stay) begin
                     ext_q <= 1'h1;
                     state_q <= irq_pkg::ST_EXT;
                  end else begin
                     state_q <= irq_pkg::ST_INT;
                  end
               end
            end
            irq_pkg::ST_INT: begin
               // chip-select autovector stays silent for internal winners
               mon_q <= mon_q + 16'h0001;
               if (link.int_done) begin
                  vec_q <= link.vec_data;
                  state_q <= irq_pkg::ST_VEC;
               end else if (!link.autovector_request_n || autovector_request_tied) begin
                  vec_q <= autovec;
                  state_q <= irq_pkg::ST_VEC;
               end else if (mon_q == MON_LAST) begin
                  bus_error_signal_q <= 1'h1;
                  spur_q <= 1'h1;
                  vec_q <= SPURIOUS_VECTOR;
                  state_q <= irq_pkg::ST_VEC;
               end
            end
            irq_pkg::ST_EXT: begin
               mon_q <= mon_q + 16'h0001;
               if (cs_autovector_request_q[ack_lvl_q] || !link.autovector_request_n || autovector_request_tied) begin
                  vec_q <= autovec;
                  state_q <= irq_pkg::ST_VEC;
               end else if (!link.data_size_acknowledge_n) begin
                  vec_q <= link.vec_data;
                  state_q <= irq_pkg::ST_VEC;
               end else if (mon_q == MON_LAST) begin
                  bus_error_signal_q <= 1'h1;
                  spur_q <= 1'h1;
                  vec_q <= SPURIOUS_VECTOR;
                  state_q <= irq_pkg::ST_VEC;
               end
            end
            irq_pkg::ST_VEC: begin
               iack_q <= 1'h0;
               ext_q <= 1'h0;
               bus_error_signal_q <= 1'h0;
               fetch_req <= 1'h1;
               fetch_addr <= vbr_q + {22'h0, vec_q, 2'h0};
               state_q <= irq_pkg::ST_FETCH;
            end
            irq_pkg::ST_FETCH: begin
               fetch_req <= 1'h0;
               if (fetch_valid) begin
                  pc <= fetch_data;
                  state_q <= irq_pkg::ST_IDLE;
               end
            end
            default: state_q <= irq_pkg::ST_IDLE;
         endcase
      end
   end

endmodule // irq_arbiter_dev
`default_nettype wire

// ==== irq_asserts.sv ====
`default_nettype none
module irq_asserts (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // acknowledge bus
   input wire logic iack,
   input wire logic ext_cycle,
   input wire logic bus_error_signal,
   input wire logic dev_arb_bit,
   input wire logic [2:0] function_code_lines,
   input wire logic [23:0] addr
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // acknowledge cycle checks
   // ------------------------------------------------------------
   property p_fc; iack |-> function_code_lines == 3'h7; endproperty
   a_fc: assert property (p_fc) else $error("fc not cpu space");
   property p_addr; iack |-> addr[23:4] == 20'hFFFFF && addr[0]; endproperty
   a_addr: assert property (p_addr) else $error("ack address wrong");
   property p_lvl; iack |-> addr[3:1] != 3'h0; endproperty
   a_lvl: assert property (p_lvl) else $error("ack level zero");
   property p_hold; iack && $past(iack) |-> $stable(addr); endproperty
   a_hold: assert property (p_hold) else $error("ack address moved");
   property p_ext; ext_cycle |-> iack; endproperty
   a_ext: assert property (p_ext) else $error("external pass outside ack");
   // the external bus only sees the cycle once four contention bits are done
   property p_late; $rose(iack) |-> !ext_cycle [*5]; endproperty
   a_late: assert property (p_late) else $error("external pass too early");
   property p_arb; dev_arb_bit |-> iack; endproperty
   a_arb: assert property (p_arb) else $error("contention outside ack");
   property p_bus_error_signal; bus_error_signal |=> !bus_error_signal && !iack; endproperty
   a_bus_error_signal: assert property (p_bus_error_signal) else $error("bus error not ending cycle");
endmodule // irq_asserts
`default_nettype wire

// ==== irq_link_if.sv ====
`default_nettype none
interface irq_link_if;
   logic [7:1] imb_irq_n;
   logic [7:1] ext_irq_n;
   logic iack;
   logic ext_cycle;
   logic bus_error_signal;
   logic [2:0] function_code_lines;
   logic [23:0] addr;
   logic dev_arb_bit;
   logic req_arb_bit;
   logic arb_wire;
   logic int_done;
   logic data_size_acknowledge_n;
   logic autovector_request_n;
   logic [7:0] vec_data;

   // contention line is a wired-or of every contender's bit
   assign arb_wire = dev_arb_bit | req_arb_bit;

   modport device (
      input imb_irq_n, ext_irq_n, arb_wire, int_done,
      input data_size_acknowledge_n, autovector_request_n, vec_data,
      output iack, ext_cycle, bus_error_signal, function_code_lines, addr, dev_arb_bit
   );

   modport requester (
      input iack, ext_cycle, bus_error_signal, function_code_lines, addr, arb_wire,
      output imb_irq_n, ext_irq_n, req_arb_bit, int_done,
      output data_size_acknowledge_n, autovector_request_n, vec_data
   );
endinterface
`default_nettype wire

// ==== irq_pkg.sv ====
`default_nettype none
package irq_pkg;

   // --------------------------------------------------------------------
   // controller register offsets
   // --------------------------------------------------------------------
   localparam logic [4:0] ADDR_SR = 5'h00;
   localparam logic [4:0] ADDR_ARB = 5'h04;
   localparam logic [4:0] ADDR_PIT = 5'h08;
   localparam logic [4:0] ADDR_CS = 5'h0C;
   localparam logic [4:0] ADDR_VBR = 5'h10;
   localparam logic [4:0] ADDR_LAST = 5'h14;
   localparam logic [4:0] ADDR_PC = 5'h18;

   // --------------------------------------------------------------------
   // field positions and reset values
   // --------------------------------------------------------------------
   localparam int SR_S_BIT = 13;
   localparam int SR_T0_BIT = 14;
   localparam int SR_T1_BIT = 15;
   localparam logic [15:0] SR_RESET = 16'h2007;
   localparam logic [2:0] MASK_ALL = 3'h7;
   localparam logic [2:0] LVL_NMI = 3'h7;
   localparam logic [2:0] LVL_NONE = 3'h0;
   localparam logic [3:0] SIU_ARB_RESET = 4'hF;
   localparam logic [3:0] MOD_ARB_RESET = 4'h0;
   localparam logic [2:0] PIT_LVL_RESET = 3'h0;
   localparam logic [7:0] PIT_VEC_RESET = 8'h00;
   localparam logic [7:1] CS_AUTOVECTOR_REQUEST_RESET = 7'h00;

   // --------------------------------------------------------------------
   // acknowledge cycle encoding
   // --------------------------------------------------------------------
   localparam logic [2:0] FC_CPU_SPACE = 3'h7;
   localparam logic [19:0] IACK_ADDR_HI = 20'hFFFFF;
   localparam logic [1:0] ARB_MSB = 2'h3;

   // --------------------------------------------------------------------
   // state machines
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ACK = 3'h1,
      ST_ARB = 3'h2,
      ST_INT = 3'h3,
      ST_EXT = 3'h4,
      ST_VEC = 3'h5,
      ST_FETCH = 3'h6
   } dev_state_t;

   typedef enum logic [2:0] {
      RQ_IDLE = 3'h0,
      RQ_PEND = 3'h1,
      RQ_ARB = 3'h2,
      RQ_HOLD = 3'h3,
      RQ_RESP = 3'h4
   } req_state_t;

endpackage
`default_nettype wire

// ==== irq_requester.sv ====
`default_nettype none
module irq_requester (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // link to the controller
   irq_link_if.requester link,
   // user side
   input wire logic req_start,
   input wire logic [2:0] req_level,
   input wire logic [3:0] arb_value,
   input wire logic [7:0] vector,
   input wire logic use_autovector,
   input wire logic on_external_pins,
   input wire logic respond,
   output logic pending,
   output logic served
);

   irq_pkg::req_state_t state_q;
   logic [2:0] lvl_q;
   logic [3:0] arb_q;
   logic [7:0] vec_cfg_q;
   logic autovector_request_cfg_q, ext_cfg_q, bit_q, in_q, stay, lvl_match, resp_go;
   logic [1:0] idx_q;
   logic [7:1] imb_n_q, ext_n_q;
   logic int_done_q, data_size_acknowledge_n_q, autovector_request_n_q;
   logic [7:0] data_q;

   function automatic logic [7:1] level_bit(input logic [2:0] l);
      level_bit = 7'h00;
      for (int i = 1; i <= 7; i++) begin
         level_bit[i] = l == 3'(i);
      end
   endfunction

   assign link.imb_irq_n = imb_n_q;
   assign link.ext_irq_n = ext_n_q;
   assign link.req_arb_bit = bit_q;
   assign link.int_done = int_done_q;
   assign link.data_size_acknowledge_n = data_size_acknowledge_n_q;
   assign link.autovector_request_n = autovector_request_n_q;
   assign link.vec_data = data_q;

   assign lvl_match = link.iack && link.function_code_lines == irq_pkg::FC_CPU_SPACE &&
      link.addr[3:1] == lvl_q;
   assign stay = in_q & (bit_q == link.arb_wire);
   assign resp_go = (state_q == irq_pkg::RQ_PEND && ext_cfg_q && link.ext_cycle &&
      lvl_match && respond) ||
      (state_q == irq_pkg::RQ_ARB && idx_q == 2'h0 && stay && arb_q != 4'h0);

   // --------------------------------------------------------------------
   // request, contention and response
   // --------------------------------------------------------------------
   // a loser waits for the acknowledge to end so it cannot re-enter the same one
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= irq_pkg::RQ_IDLE;
         lvl_q <= irq_pkg::LVL_NONE;
         arb_q <= irq_pkg::MOD_ARB_RESET;
         vec_cfg_q <= 8'h00;
         autovector_request_cfg_q <= 1'h0;
         ext_cfg_q <= 1'h0;
         bit_q <= 1'h0;
         in_q <= 1'h0;
         idx_q <= 2'h0;
         imb_n_q <= 7'h7F;
         ext_n_q <= 7'h7F;
         int_done_q <= 1'h0;
         data_size_acknowledge_n_q <= 1'h1;
         autovector_request_n_q <= 1'h1;
         data_q <= 8'h00;
         pending <= 1'h0;
         served <= 1'h0;
      end else if (resp_go) begin
         imb_n_q <= 7'h7F;
         ext_n_q <= 7'h7F;
         bit_q <= 1'h0;
         in_q <= 1'h0;
         pending <= 1'h0;
         served <= 1'h1;
         if (autovector_request_cfg_q) begin
            autovector_request_n_q <= 1'h0;
         end else begin
            data_q <= vec_cfg_q;
            data_size_acknowledge_n_q <= ~ext_cfg_q;
            int_done_q <= ~ext_cfg_q;
         end
         state_q <= irq_pkg::RQ_RESP;
      end else begin
         unique case (state_q)
            irq_pkg::RQ_IDLE: if (req_start && req_level != irq_pkg::LVL_NONE) begin
               lvl_q <= req_level;
               arb_q <= arb_value;
               vec_cfg_q <= vector;
               autovector_request_cfg_q <= use_autovector;
               ext_cfg_q <= on_external_pins;
               if (on_external_pins) begin
                  ext_n_q <= ~level_bit(req_level);
               end else begin
                  imb_n_q <= ~level_bit(req_level);
               end
               pending <= 1'h1;
               state_q <= irq_pkg::RQ_PEND;
            end
            irq_pkg::RQ_PEND: if (!ext_cfg_q && lvl_match) begin
               idx_q <= irq_pkg::ARB_MSB;
               in_q <= 1'h1;
               bit_q <= arb_q[irq_pkg::ARB_MSB];
               state_q <= irq_pkg::RQ_ARB;
            end
            irq_pkg::RQ_ARB: begin
               if (idx_q != 2'h0) begin
                  in_q <= stay;
                  bit_q <= stay & arb_q[idx_q - 2'h1];
                  idx_q <= idx_q - 2'h1;
               end else begin
                  in_q <= 1'h0;
                  bit_q <= 1'h0;
                  state_q <= irq_pkg::RQ_HOLD;
               end
            end
            irq_pkg::RQ_HOLD: if (!link.iack) begin
               state_q <= irq_pkg::RQ_PEND;
            end
            irq_pkg::RQ_RESP: begin
               int_done_q <= 1'h0;
               data_size_acknowledge_n_q <= 1'h1;
               autovector_request_n_q <= 1'h1;
               served <= 1'h0;
               state_q <= irq_pkg::RQ_IDLE;
            end
            default: state_q <= irq_pkg::RQ_IDLE;
         endcase
      end
   end

endmodule // irq_requester
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic reg_write = 1'b0, reg_read = 1'b0, instr_boundary = 1'b0, exc_done = 1'b0;
   logic periodic_tick = 1'b0, fetch_valid = 1'b0, req_start = 1'b0, use_av = 1'b0;
   logic ext_pins = 1'b0, respond = 1'b0, stack_req, fetch_req, pending, served;
   logic autovector_request_tied = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0, fetch_data = 32'h0, reg_rdata, fetch_addr, pc, rv;
   logic [2:0] req_level = 3'h0;
   logic [3:0] arb_value = 4'h0;
   logic [7:0] vector = 8'h00;
   logic [15:0] stacked_sr;
   int n_mismatch = 0;
   int num_checks = 0;
   always #12.5 clock = ~clock;
   irq_link_if link ();
   irq_arbiter_dev #(.BUS_MON_CYCLES(8)) irq_arbiter_dev_i (.clock(clock), .reset(reset),
      .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .instr_boundary(instr_boundary),
      .exc_done(exc_done), .periodic_tick(periodic_tick), .autovector_request_tied(autovector_request_tied),
      .fetch_valid(fetch_valid), .fetch_data(fetch_data), .stack_req(stack_req),
      .stacked_sr(stacked_sr), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .pc(pc));
   irq_requester irq_requester_i (.clock(clock), .reset(reset), .link(link),
      .req_start(req_start), .req_level(req_level), .arb_value(arb_value), .vector(vector),
      .use_autovector(use_av), .on_external_pins(ext_pins), .respond(respond),
      .pending(pending), .served(served));
   irq_asserts irq_asserts_i (.clock(clock), .reset(reset), .iack(link.iack),
      .ext_cycle(link.ext_cycle), .bus_error_signal(link.bus_error_signal),
      .dev_arb_bit(link.dev_arb_bit), .function_code_lines(link.function_code_lines),
      .addr(link.addr));
   // vector table memory: answers one cycle after each fetch
   always @(posedge clock) begin
      fetch_valid <= fetch_req;
      fetch_data <= 32'hA0000000 | fetch_addr;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic do_reset();
      @(posedge clock);
      reset <= 1'b1;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      wr(irq_pkg::ADDR_VBR, 32'h100);
   endtask
   task automatic req(input logic [2:0] l, input logic [3:0] a, input logic [7:0] v,
                      input logic av, input logic ex, input logic rs);
      @(posedge clock);
      req_level <= l;
      arb_value <= a;
      vector <= v;
      use_av <= av;
      ext_pins <= ex;
      respond <= rs;
      req_start <= 1'b1;
      @(posedge clock);
      req_start <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task automatic go(input logic ex);
      @(posedge clock);
      exc_done <= ex;
      instr_boundary <= !ex;
      @(posedge clock);
      exc_done <= 1'b0;
      instr_boundary <= 1'b0;
   endtask
   // waits for the vector fetch, then checks table address, status and capture
   task automatic fin(input logic [2:0] l, input logic [7:0] v);
      for (int i = 0; i < 300 && fetch_req !== 1'b1; i++) @(posedge clock);
      repeat (3) @(posedge clock);
      check(pc, 32'hA0000100 + {22'h0, v, 2'b00});
      check({29'h0, stacked_sr[15:13]}, 32'h6);
      rd(irq_pkg::ADDR_LAST);
      check(rv & 32'h7FF, {21'h0, l, v});
      rd(irq_pkg::ADDR_SR);
      check(rv & 32'hE007, {29'h00000400, l});
      wr(irq_pkg::ADDR_SR, 32'hC000);
      $display("test level %0d vector %h done", l, v);
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      #200us;
      n_mismatch++;
      complete_run();
   end
   initial begin
      do_reset();
      rd(irq_pkg::ADDR_ARB);
      check(rv, 32'hF);
      rd(irq_pkg::ADDR_SR);
      check(rv & 32'hE007, 32'h2007);
      rd(5'h1C);
      check(rv, 32'h0);
      wr(irq_pkg::ADDR_SR, 32'hC005);
      req(3'h4, 4'h5, 8'h40, 1'b0, 1'b0, 1'b1);
      go(1'b0);
      repeat (10) @(posedge clock);
      check({31'h0, pending}, 32'h1);
      wr(irq_pkg::ADDR_SR, 32'hC000);
      go(1'b0);
      fin(3'h4, 8'h40);
      req(3'h5, 4'h0, 8'h55, 1'b0, 1'b1, 1'b1);
      go(1'b0);
      fin(3'h5, 8'h55);
      req(3'h2, 4'h0, 8'h00, 1'b1, 1'b1, 1'b1);
      go(1'b0);
      fin(3'h2, 8'h1A);
      wr(irq_pkg::ADDR_PIT, 32'h7703);
      @(posedge clock);
      periodic_tick <= 1'b1;
      @(posedge clock);
      periodic_tick <= 1'b0;
      go(1'b1);
      fin(3'h3, 8'h77);
      wr(irq_pkg::ADDR_SR, 32'hC007);
      req(3'h7, 4'h9, 8'h70, 1'b0, 1'b0, 1'b1);
      go(1'b0);
      fin(3'h7, 8'h70);
      autovector_request_tied <= 1'b1;
      req(3'h1, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1);
      go(1'b0);
      fin(3'h1, 8'h19);
      autovector_request_tied <= 1'b0;
      wr(irq_pkg::ADDR_CS, 32'h40);
      req(3'h6, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1);
      go(1'b0);
      fin(3'h6, 8'h1E);
      req(3'h6, 4'h3, 8'h66, 1'b0, 1'b0, 1'b1);
      go(1'b0);
      fin(3'h6, 8'h66);
      req(3'h4, 4'h0, 8'h00, 1'b0, 1'b1, 1'b0);
      go(1'b0);
      fin(3'h4, 8'h18);
      do_reset();
      wr(irq_pkg::ADDR_SR, 32'hC000);
      req(3'h6, 4'h0, 8'h33, 1'b0, 1'b0, 1'b1);
      go(1'b0);
      fin(3'h6, 8'h18);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
